// ===== rtl/ccr_params.svh
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH

// register indices; byte address is four times the index
`define CCR_IDX_OSC        8'h40
`define CCR_IDX_CPLL       8'h44
`define CCR_IDX_MSPEED     8'h58
`define CCR_IDX_IODELAY    8'h5C
`define CCR_IDX_MINDEX     8'h60
`define CCR_IDX_MDATA      8'h64
`define CCR_IDX_BIU        8'h68
`define CCR_IDX_REGUL      8'h6C
`define CCR_IDX_CPLL3      8'h70
`define CCR_IDX_GSTATE     8'h74
`define CCR_IDX_MISC1      8'h78
`define CCR_IDX_MISC2      8'h7C
`define CCR_IDX_DLLTRIM    8'h80
`define CCR_IDX_SCRATCH    8'h84
`define CCR_IDX_CMDA       8'h88
`define CCR_IDX_CMDB       8'h89
`define CCR_IDX_GATE2      8'h8C

// reset values
`define CCR_RST_OSC        32'h0004_0001
`define CCR_RST_IODELAY    32'h0000_0042
`define CCR_RST_BIU        32'h0003_109F
`define CCR_RST_REGUL      32'h0000_0080
`define CCR_RST_CPLL3      32'h0200_0001
`define CCR_RST_GATE2      32'h87C4_7F3F
`define CCR_RST_ZERO       32'h0000_0000

// writable masks
`define CCR_MASK_ALL       32'hFFFF_FFFF
`define CCR_MASK_OSC       32'hFFFB_FFFF
`define CCR_MASK_HALF      32'h0000_FFFF
`define CCR_MASK_INDEX     32'h0003_FFFF
`define CCR_MASK_BYTE      32'h0000_00FF

// field positions
`define CCR_SPEED_LSB      0
`define CCR_SPEED_MSB      1
`define CCR_SPEED_SRC_BIT  2
`define CCR_SPEED_UNDEF    2'h3
`define CCR_INTSRC_BIT     18
`define CCR_PHASE_LSB      3
`define CCR_IO_MST_BIT     13
`define CCR_IO_SLV_BIT     14
`define CCR_ENGINE_BIT     20
`define CCR_DISPLAY_BIT    21
`define CCR_MEMBR_BIT      25
`define CCR_LENGTHEN_BIT   30

// timing
`define CCR_MCLK_KHZ       40000
`define CCR_STOP_DELAY_NS  61000
// scale to microseconds first so the product stays inside a 32-bit int
`define CCR_STOP_CYCLES    ((`CCR_STOP_DELAY_NS / 1000) * `CCR_MCLK_KHZ / 1000)
`define CCR_DELAY_SHORT    16
`define CCR_DELAY_LONG     32

// indirect table
`define CCR_TABLE_DEPTH    16
`define CCR_TABLE_AW       4

`endif

// ===== rtl/ccr_pkg.sv
package ccr_pkg;
    // graphics clock sequencer states, gray along the usual path
    typedef enum logic [1:0] {
        GFX_ACTIVE  = 2'h0,
        GFX_SUSPEND = 2'h1,
        GFX_STOPPED = 2'h3,
        GFX_WAKING  = 2'h2
    } ccr_gfx_state_t;

    typedef logic [31:0] ccr_word_t;
    typedef logic [1:0]  ccr_phase_t;
endpackage : ccr_pkg

// ===== rtl/ccr_ctl_if.sv
`timescale 1ns/100ps
interface ccr_ctl_if;
    logic               ce;
    logic               tableWr;
    logic [17:0]        tablePtr;
    ccr_pkg::ccr_word_t tableWdata;
    ccr_pkg::ccr_word_t tableRdata;
    logic               fullPower;
    logic               suspendSeen;
    logic               busClockHold;
    ccr_pkg::ccr_phase_t phase;
    logic               busClocksRun;

    modport ctl (output ce, output tableWr, output tablePtr, output tableWdata, input tableRdata,
                 output fullPower, output suspendSeen, output busClockHold,
                 input phase, input busClocksRun);
    modport table_side (input ce, input tableWr, input tablePtr, input tableWdata, output tableRdata);
    modport gfx_side (input ce, input fullPower, input suspendSeen, input busClockHold,
                      output phase, output busClocksRun);
endinterface : ccr_ctl_if

// ===== rtl/ccr_mem_table.sv
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_mem_table (
    input wire logic    mclk,
    input wire logic    reset,
    ccr_ctl_if.table_side bus
);
    ccr_pkg::ccr_word_t entry_q [`CCR_TABLE_DEPTH];
    logic [`CCR_TABLE_AW-1:0] slot;
    logic                     inRange;

    // pointer selects one setting; pointers past the table read zero
    assign slot    = bus.tablePtr[`CCR_TABLE_AW-1:0];
    assign inRange = (bus.tablePtr[17:`CCR_TABLE_AW] == '0);
    assign bus.tableRdata = inRange ? entry_q[slot] : `CCR_RST_ZERO;

    // one flip-flop word per setting
    genvar g;
    generate
        for (g = 0; g < `CCR_TABLE_DEPTH; g++) begin : gEntry
            always_ff @(posedge mclk) begin
                if (reset) begin
                    entry_q[g] <= `CCR_RST_ZERO;
                end else if (bus.ce && bus.tableWr && inRange && (slot == g)) begin
                    entry_q[g] <= bus.tableWdata;
                end
            end
        end
    endgenerate
endmodule : ccr_mem_table

// ===== rtl/ccr_gfx_seq.sv
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_gfx_seq (
    input wire logic    mclk,
    input wire logic    reset,
    ccr_ctl_if.gfx_side bus
);
    ccr_pkg::ccr_gfx_state_t state_q, state_d;
    logic [11:0]             stopCnt_q;
    logic                    stopDone;

    assign stopDone = (stopCnt_q == 12'(`CCR_STOP_CYCLES - 1));

    // suspend, stop after the delay, wake back to full power
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ccr_pkg::GFX_ACTIVE:  if (bus.suspendSeen) state_d = ccr_pkg::GFX_SUSPEND;
            ccr_pkg::GFX_SUSPEND: if (bus.fullPower) state_d = ccr_pkg::GFX_ACTIVE;
                                  else if (stopDone) state_d = ccr_pkg::GFX_STOPPED;
            ccr_pkg::GFX_STOPPED: if (!bus.busClockHold) state_d = ccr_pkg::GFX_WAKING;
            ccr_pkg::GFX_WAKING:  if (bus.fullPower) state_d = ccr_pkg::GFX_ACTIVE;
        endcase
    end

    // state and stop-delay counter
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q   <= ccr_pkg::GFX_ACTIVE;
            stopCnt_q <= 12'h000;
        end else if (bus.ce) begin
            state_q   <= state_d;
            stopCnt_q <= (state_q == ccr_pkg::GFX_SUSPEND) ? stopCnt_q + 12'h001 : 12'h000;
        end
    end

    // full power reads 0, suspend reads 3, waking reads 1
    assign bus.phase = (state_q == ccr_pkg::GFX_ACTIVE) ? 2'h0 :
                       (state_q == ccr_pkg::GFX_WAKING) ? 2'h1 : 2'h3;
    // clear hold bit forces the bus clock on
    assign bus.busClocksRun = (state_q != ccr_pkg::GFX_STOPPED) || !bus.busClockHold;
endmodule : ccr_gfx_seq

// ===== rtl/ccr_clock_config.sv
// What this block does
// - scratch fields store and return writes but steer no clock logic
// - speed code 0 is 66 MHz, 1 is 100 MHz, 2 is 133 MHz, 3 undefined
// - source bit clear follows front-side bus speed, set uses programmed code
// - graphics phase reads 0 at full power, 3 at suspend; with the hold bit set, bus clocks stop 61 us later
// - delay lengthen bit selects 16 or 32 clock delay timer, resets clear
// - gate register bit 20 stops the graphics engine clock, resets clear
// - gate register bit 21 stops the graphics display clock, resets clear
// - bits 13 and 14, reset set, disable gating on io master and slave branches
// - bit 25, reset set, keeps gating off on memory branch to bus interface
// - internal source flag bit 18 is read only, resets to one
//
// Added by the designer: strobed register access.
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_clock_config (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic [9:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    input  wire logic [1:0]  fsbSpeedCode,
    input  wire logic        memClockChange,
    input  wire logic        gfxFullPower,
    input  wire logic        gfxSuspend,
    input  wire logic        busClockHoldBit,
    output logic      [1:0]  memSpeedCode,
    output logic             memSpeedDefined,
    output logic             memDelayBusy,
    output logic             engineClockRun,
    output logic             displayClockRun,
    output logic             ioMasterGatingOff,
    output logic             ioSlaveGatingOff,
    output logic             memoryBranchGatingOff,
    output logic             gfxBusClocksRun,
    output logic             internalSourceFlag
);
    localparam int NSLOT = 15;

    ccr_ctl_if ctl ();

    // slot numbers of the stored registers
    localparam int S_OSC     = 0;
    localparam int S_CPLL    = 1;
    localparam int S_MSPEED  = 2;
    localparam int S_IODELAY = 3;
    localparam int S_MINDEX  = 4;
    localparam int S_BIU     = 5;
    localparam int S_REGUL   = 6;
    localparam int S_CPLL3   = 7;
    localparam int S_MISC1   = 8;
    localparam int S_MISC2   = 9;
    localparam int S_DLLTRIM = 10;
    localparam int S_SCRATCH = 11;
    localparam int S_CMDA    = 12;
    localparam int S_CMDB    = 13;
    localparam int S_GATE2   = 14;

    // register index of each slot
    function automatic logic [7:0] slotIndex(input int s);
        logic [7:0] idx;
        idx = 8'h00;
        case (s)
            S_OSC:     idx = `CCR_IDX_OSC;
            S_CPLL:    idx = `CCR_IDX_CPLL;
            S_MSPEED:  idx = `CCR_IDX_MSPEED;
            S_IODELAY: idx = `CCR_IDX_IODELAY;
            S_MINDEX:  idx = `CCR_IDX_MINDEX;
            S_BIU:     idx = `CCR_IDX_BIU;
            S_REGUL:   idx = `CCR_IDX_REGUL;
            S_CPLL3:   idx = `CCR_IDX_CPLL3;
            S_MISC1:   idx = `CCR_IDX_MISC1;
            S_MISC2:   idx = `CCR_IDX_MISC2;
            S_DLLTRIM: idx = `CCR_IDX_DLLTRIM;
            S_SCRATCH: idx = `CCR_IDX_SCRATCH;
            S_CMDA:    idx = `CCR_IDX_CMDA;
            S_CMDB:    idx = `CCR_IDX_CMDB;
            S_GATE2:   idx = `CCR_IDX_GATE2;
            default:   idx = 8'h00;
        endcase
        return idx;
    endfunction : slotIndex

    // reset value of each slot
    function automatic logic [31:0] slotReset(input int s);
        logic [31:0] v;
        v = `CCR_RST_ZERO;
        case (s)
            S_OSC:     v = `CCR_RST_OSC;
            S_IODELAY: v = `CCR_RST_IODELAY;
            S_BIU:     v = `CCR_RST_BIU;
            S_REGUL:   v = `CCR_RST_REGUL;
            S_CPLL3:   v = `CCR_RST_CPLL3;
            S_GATE2:   v = `CCR_RST_GATE2;
            default:   v = `CCR_RST_ZERO;
        endcase
        return v;
    endfunction : slotReset

    // writable bits of each slot; narrow registers keep only their low bits
    function automatic logic [31:0] slotMask(input int s);
        logic [31:0] m;
        m = `CCR_MASK_ALL;
        case (s)
            S_OSC:    m = `CCR_MASK_OSC;
            S_MSPEED: m = `CCR_MASK_HALF;
            S_MINDEX: m = `CCR_MASK_INDEX;
            S_CMDA:   m = `CCR_MASK_BYTE;
            S_CMDB:   m = `CCR_MASK_BYTE;
            default:  m = `CCR_MASK_ALL;
        endcase
        return m;
    endfunction : slotMask

    // address decode: word aligned, index in the upper bits
    logic [7:0]         regIdx;
    logic               aligned;
    logic [NSLOT-1:0]   slotHit;
    logic               hitData;
    logic               hitGstate;
    logic               anyHit;

    assign regIdx    = regAddr[9:2];
    assign aligned   = (regAddr[1:0] == 2'h0);
    assign hitData   = aligned && (regIdx == `CCR_IDX_MDATA);
    assign hitGstate = aligned && (regIdx == `CCR_IDX_GSTATE);
    assign anyHit    = (|slotHit) || hitData || hitGstate;

    // stored registers, one per slot
    ccr_pkg::ccr_word_t store_q [NSLOT];
    ccr_pkg::ccr_word_t slotRead [NSLOT];

    genvar g;
    generate
        for (g = 0; g < NSLOT; g++) begin : gSlot
            localparam logic [31:0] RST  = slotReset(g);
            localparam logic [31:0] MASK = slotMask(g);

            assign slotHit[g]  = aligned && (regIdx == slotIndex(g));
            assign slotRead[g] = slotHit[g] ? store_q[g] : `CCR_RST_ZERO;

            // scratch and control storage; read-only bits keep their reset value
            always_ff @(posedge mclk) begin
                if (reset) begin
                    store_q[g] <= RST;
                end else if (ce && regWr && slotHit[g]) begin
                    store_q[g] <= (regWdata & MASK) | (store_q[g] & ~MASK);
                end
            end
        end
    endgenerate

    // or-reduce the per-slot read words
    ccr_pkg::ccr_word_t storeRead;
    always_comb begin
        storeRead = `CCR_RST_ZERO;
        for (int s = 0; s < NSLOT; s++) begin
            storeRead = storeRead | slotRead[s];
        end
    end

    // read mux: stored slots, indirect data, graphics state; unmapped reads zero
    ccr_pkg::ccr_word_t readMux;
    assign readMux = hitData   ? ctl.tableRdata :
                     hitGstate ? {27'h0, ctl.phase, 3'h0} :
                     anyHit    ? storeRead : `CCR_RST_ZERO;

    // read data stands only in the cycle after the strobe
    logic [31:0] rdata_q;
    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_q <= `CCR_RST_ZERO;
        end else if (ce) begin
            rdata_q <= regRd ? readMux : `CCR_RST_ZERO;
        end
    end
    assign regRdata = rdata_q;

    // indirect access through pointer and data registers
    assign ctl.ce         = ce;
    assign ctl.tablePtr   = store_q[S_MINDEX][17:0];
    assign ctl.tableWr    = regWr && hitData;
    assign ctl.tableWdata = regWdata;

    ccr_mem_table uTable (
        .mclk  (mclk),
        .reset (reset),
        .bus   (ctl)
    );

    // graphics clock sequencer
    assign ctl.fullPower    = gfxFullPower;
    assign ctl.suspendSeen  = gfxSuspend;
    assign ctl.busClockHold = busClockHoldBit;

    ccr_gfx_seq uGfx (
        .mclk  (mclk),
        .reset (reset),
        .bus   (ctl)
    );

    assign gfxBusClocksRun = ctl.busClocksRun;

    // memory clock speed: programmed code or front-side bus code
    logic [1:0] speedCode;
    logic       speedSrc;
    logic [1:0] speedSel;
    logic [1:0] memSpeed_q;

    assign speedCode = store_q[S_MSPEED][`CCR_SPEED_MSB:`CCR_SPEED_LSB];
    assign speedSrc  = store_q[S_MSPEED][`CCR_SPEED_SRC_BIT];
    assign speedSel  = speedSrc ? speedCode : fsbSpeedCode;

    always_ff @(posedge mclk) begin
        if (reset) begin
            memSpeed_q <= 2'h0;
        end else if (ce) begin
            memSpeed_q <= speedSel;
        end
    end
    assign memSpeedCode    = memSpeed_q;
    assign memSpeedDefined = (memSpeed_q != `CCR_SPEED_UNDEF);

    // memory clock delay timer, 16 or 32 clocks per change
    logic [5:0] delayCnt_q;
    logic [5:0] delayLen;
    logic       lengthen;

    assign lengthen = store_q[S_GATE2][`CCR_LENGTHEN_BIT];
    assign delayLen = lengthen ? 6'(`CCR_DELAY_LONG) : 6'(`CCR_DELAY_SHORT);

    always_ff @(posedge mclk) begin
        if (reset) begin
            delayCnt_q <= 6'h00;
        end else if (ce) begin
            if (memClockChange) begin
                delayCnt_q <= delayLen;
            end else if (delayCnt_q != 6'h00) begin
                delayCnt_q <= delayCnt_q - 6'h01;
            end
        end
    end
    assign memDelayBusy = (delayCnt_q != 6'h00);

    // clock branch controls from the second gate register
    assign engineClockRun        = !store_q[S_GATE2][`CCR_ENGINE_BIT];
    assign displayClockRun       = !store_q[S_GATE2][`CCR_DISPLAY_BIT];
    assign ioMasterGatingOff     = store_q[S_GATE2][`CCR_IO_MST_BIT];
    assign ioSlaveGatingOff      = store_q[S_GATE2][`CCR_IO_SLV_BIT];
    assign memoryBranchGatingOff = store_q[S_GATE2][`CCR_MEMBR_BIT];

    // clock source indicator, read-only
    assign internalSourceFlag    = store_q[S_OSC][`CCR_INTSRC_BIT];
endmodule : ccr_clock_config

// ===== tb/ccr_clock_config_assertions.sv
`timescale 1ns/100ps
module ccr_clock_config_checker (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        ce,
    input wire logic [9:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdata,
    input wire logic        memClockChange,
    input wire logic        busClockHoldBit,
    input wire logic [1:0]  memSpeedCode,
    input wire logic        memSpeedDefined,
    input wire logic        memDelayBusy,
    input wire logic        engineClockRun,
    input wire logic        displayClockRun,
    input wire logic        ioMasterGatingOff,
    input wire logic        ioSlaveGatingOff,
    input wire logic        memoryBranchGatingOff,
    input wire logic        gfxBusClocksRun
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // decoded accesses
    wire gateWr = ce && regWr && regAddr == 10'h230;
    wire scrWr  = ce && regWr && regAddr == 10'h210;
    wire oscRd  = ce && regRd && regAddr == 10'h100;
    wire phRd   = ce && regRd && regAddr == 10'h1D0;
    wire spdWr  = ce && regWr && regAddr == 10'h160;

    engine_off_a: assert property (gateWr |=> engineClockRun == !$past(regWdata[20]))
        else $error("engine clock does not follow its off bit");
    display_off_a: assert property (gateWr |=> displayClockRun == !$past(regWdata[21]))
        else $error("display clock does not follow its off bit");
    io_gating_a: assert property (gateWr |=> ioMasterGatingOff == $past(regWdata[13])
        && ioSlaveGatingOff == $past(regWdata[14])) else $error("io gating does not follow its bits");
    mem_branch_a: assert property (gateWr |=> memoryBranchGatingOff == $past(regWdata[25]))
        else $error("memory branch gating does not follow its bit");
    source_read_a: assert property (oscRd |=> regRdata[18])
        else $error("internal source flag reads clear");
    speed_valid_a: assert property (memSpeedDefined == (memSpeedCode != 2'h3))
        else $error("speed defined flag wrong");
    speed_prog_a: assert property (spdWr && regWdata[2] |-> ##2 memSpeedCode == $past(regWdata[1:0], 2))
        else $error("programmed speed code not applied");
    delay_busy_a: assert property (ce && memClockChange |=> memDelayBusy [*8])
        else $error("delay timer ended too early");
    scratch_quiet_a: assert property (scrWr |=> $stable(engineClockRun) && $stable(displayClockRun)
        && $stable(memoryBranchGatingOff)) else $error("scratch write moved a clock control");
    phase_read_a: assert property (phRd |=> (regRdata & 32'hFFFF_FFE7) == 32'h0)
        else $error("graphics state register shows bits outside phase");
    bus_stop_a: assert property ($fell(gfxBusClocksRun) |-> busClockHoldBit)
        else $error("bus clocks stopped while hold bit clear");

    // main scenarios reached
    cover property (gateWr);
    cover property (memClockChange ##1 memDelayBusy);
    cover property ($fell(gfxBusClocksRun));
endmodule : ccr_clock_config_checker

bind ccr_clock_config ccr_clock_config_checker chk (.mclk(mclk), .reset(reset), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .memClockChange(memClockChange),
    .busClockHoldBit(busClockHoldBit), .memSpeedCode(memSpeedCode), .memSpeedDefined(memSpeedDefined),
    .memDelayBusy(memDelayBusy), .engineClockRun(engineClockRun), .displayClockRun(displayClockRun),
    .ioMasterGatingOff(ioMasterGatingOff), .ioSlaveGatingOff(ioSlaveGatingOff),
    .memoryBranchGatingOff(memoryBranchGatingOff), .gfxBusClocksRun(gfxBusClocksRun));

// ===== tb/tb_ccr_clock_config.sv
`timescale 1ns/100ps
module tb_ccr_clock_config;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        ce = 1'b1;
    logic [9:0]  regAddr = 10'h000;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [1:0]  fsbSpeedCode = 2'h1;
    logic        memClockChange = 1'b0;
    logic        gfxFullPower = 1'b0;
    logic        gfxSuspend = 1'b0;
    logic        busClockHoldBit = 1'b1;
    wire  [31:0] regRdata;
    wire  [1:0]  memSpeedCode;
    wire         memSpeedDefined, memDelayBusy, engineClockRun, displayClockRun, gfxBusClocksRun;
    wire         ioMasterGatingOff, ioSlaveGatingOff, memoryBranchGatingOff, internalSourceFlag;
    int          mismatches = 0;
    int          tests_run = 0;

    ccr_clock_config uut (.mclk(mclk), .reset(reset), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fsbSpeedCode(fsbSpeedCode),
        .memClockChange(memClockChange), .gfxFullPower(gfxFullPower), .gfxSuspend(gfxSuspend),
        .busClockHoldBit(busClockHoldBit), .memSpeedCode(memSpeedCode), .memSpeedDefined(memSpeedDefined),
        .memDelayBusy(memDelayBusy), .engineClockRun(engineClockRun), .displayClockRun(displayClockRun),
        .ioMasterGatingOff(ioMasterGatingOff), .ioSlaveGatingOff(ioSlaveGatingOff),
        .memoryBranchGatingOff(memoryBranchGatingOff), .gfxBusClocksRun(gfxBusClocksRun),
        .internalSourceFlag(internalSourceFlag));

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr

    // read strobe one cycle, data sampled mid-cycle after it
    task automatic rdc(input string name, input logic [9:0] a, input logic [31:0] exp);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        check(name, exp, regRdata);
    endtask : rdc

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : settle

    task automatic t_reset;
        rdc("osc", 10'h100, 32'h0004_0001);
        rdc("ioDelay", 10'h170, 32'h0000_0042);
        rdc("biu", 10'h1A0, 32'h0003_109F);
        rdc("gate", 10'h230, 32'h87C4_7F3F);
        check("flag", 32'h1, {31'h0, internalSourceFlag});
        check("ports", 32'h1F, {27'h0, engineClockRun, displayClockRun, ioMasterGatingOff, ioSlaveGatingOff,
            memoryBranchGatingOff});
        $display("test reset done");
    endtask : t_reset

    task automatic t_scratch;
        wr(10'h210, 32'hA5C3_0FF0);
        rdc("scratch", 10'h210, 32'hA5C3_0FF0);
        wr(10'h212, 32'h0);
        @(posedge mclk);
        ce <= 1'b0;
        wr(10'h210, 32'h0);
        ce <= 1'b1;
        rdc("scratchKept", 10'h210, 32'hA5C3_0FF0);
        wr(10'h100, 32'h0);
        rdc("oscReadOnly", 10'h100, 32'h0004_0000);
        wr(10'h3FC, 32'hFFFF_FFFF);
        rdc("unmapped", 10'h3FC, 32'h0);
        $display("test scratch done");
    endtask : t_scratch

    task automatic t_speed;
        logic [2:0] c;
        @(posedge mclk);
        fsbSpeedCode <= 2'h2;
        wr(10'h160, 32'h0000_0003);
        settle(3);
        check("follow", 32'h2, {30'h0, memSpeedCode});
        for (c = 3'h0; c < 3'h4; c++) begin
            wr(10'h160, {29'h1, c[1:0]});
            settle(3);
            check("speed", {30'h0, c[1:0]}, {30'h0, memSpeedCode});
            check("defined", {31'h0, c != 3'h3}, {31'h0, memSpeedDefined});
        end
        $display("test speed done");
    endtask : t_speed

    task automatic t_gate;
        wr(10'h230, 32'h0030_0000);
        settle(1);
        check("gateOff", 32'h0, {27'h0, engineClockRun, displayClockRun, ioMasterGatingOff, ioSlaveGatingOff,
            memoryBranchGatingOff});
        wr(10'h230, 32'h0200_6000);
        settle(1);
        check("gateOn", 32'h1F, {27'h0, engineClockRun, displayClockRun, ioMasterGatingOff, ioSlaveGatingOff,
            memoryBranchGatingOff});
        $display("test gate done");
    endtask : t_gate

    task automatic t_delay;
        int n;
        for (int k = 0; k < 2; k++) begin
            wr(10'h230, k ? 32'h4000_0000 : 32'h0);
            @(posedge mclk);
            memClockChange <= 1'b1;
            @(posedge mclk);
            memClockChange <= 1'b0;
            n = 0;
            @(negedge mclk);
            while (memDelayBusy === 1'b1 && n < 100) begin
                n++;
                @(negedge mclk);
            end
            check("delayLength", k ? 32'h20 : 32'h10, n);
        end
        $display("test delay done");
    endtask : t_delay

    task automatic t_index;
        wr(10'h180, 32'h5);
        wr(10'h190, 32'hCAFE_0005);
        wr(10'h180, 32'h6);
        wr(10'h190, 32'h0000_1234);
        wr(10'h180, 32'h5);
        rdc("entry", 10'h190, 32'hCAFE_0005);
        wr(10'h180, 32'hFFFF_FFFF);
        rdc("pointer", 10'h180, 32'h0003_FFFF);
        rdc("beyond", 10'h190, 32'h0);
        $display("test index done");
    endtask : t_index

    task automatic t_gfx;
        rdc("phaseActive", 10'h1D0, 32'h0);
        @(posedge mclk);
        gfxSuspend <= 1'b1;
        settle(2400);
        check("runBefore", 32'h1, {31'h0, gfxBusClocksRun});
        rdc("phaseSuspend", 10'h1D0, 32'h18);
        settle(60);
        check("stopped", 32'h0, {31'h0, gfxBusClocksRun});
        @(posedge mclk);
        gfxSuspend <= 1'b0;
        busClockHoldBit <= 1'b0;
        settle(2);
        check("wakeRun", 32'h1, {31'h0, gfxBusClocksRun});
        rdc("phaseWaking", 10'h1D0, 32'h08);
        @(posedge mclk);
        gfxFullPower <= 1'b1;
        settle(2);
        rdc("phaseAgain", 10'h1D0, 32'h0);
        settle(4000);
        @(posedge mclk);
        busClockHoldBit <= 1'b1;
        $display("test graphics done");
    endtask : t_gfx

    task automatic complete_run;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        t_reset;
        t_scratch;
        t_speed;
        t_gate;
        t_delay;
        t_index;
        t_gfx;
        complete_run;
    end

    // hang guard, about three times the expected run
    initial begin
        #500000;
        mismatches++;
        $display("watchdog expired");
        complete_run;
    end
endmodule : tb_ccr_clock_config
